// [logic/fdc_pkg.sv]
// fdc_pkg: constants, types and state record of the diskette dma controller.
// assumes a 250 MHz core clock and an apb slave port with 32-bit data.
//
// Behaviour
// - no interrupt while enable bit 13 clear
// - every finished command raises an interrupt while bit 13 set and priority below five
// - no interrupt when no command in progress
// - interrupt only below priority five; else error
// - track-zero flag bit 2 follows drive
// - failed seek or restore sets bit 4
// - track register holds current head track
// - force-bad-parity bit 11 corrupts dma write parity
// - bad parity on dma read sets bit 15
// - unanswered dma address sets nonexistent-memory flag
// - nonexistent memory never also sets parity flag
// - dma test mode moves one word, no drive
// - address counter readable with correct next address
// - address counter advances one per word
// - unserviced transfer request reports lost data
// - sector not found on track reports record-not-found
// - data field crc mismatch reports data crc error
// - header crc mismatch reports header crc error
// - drive not-ready reported to software
// - write-protect reported, writes refused
package fdc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CSR   = 8'h00;
	localparam logic [7:0] OFS_CMD   = 8'h04;
	localparam logic [7:0] OFS_TRACK = 8'h08;
	localparam logic [7:0] OFS_ADDR  = 8'h0C;
	localparam logic [7:0] OFS_DATA  = 8'h10;
	localparam logic [7:0] OFS_ERR   = 8'h14;
	// csr field positions
	localparam int CSR_PAR   = 15;
	localparam int CSR_NXM   = 14;
	localparam int CSR_IE    = 13;
	localparam int CSR_FBP   = 11;
	localparam int CSR_DONE  = 7;
	localparam int CSR_BUSY  = 6;
	localparam int CSR_SEEK  = 4;
	localparam int CSR_TRK0  = 2;
	localparam int CSR_NRDY  = 1;
	localparam int CSR_WPROT = 0;
	// cmd field positions
	localparam int CMD_OP_LO  = 0;
	localparam int CMD_TRK_LO = 3;
	localparam int CMD_SEC_LO = 10;
	// reset values
	localparam logic [15:0] RST_ADDR = 16'h0000;
	localparam logic [6:0]  RST_TRK  = 7'h00;
	// timing: step pulse width and step rate
	localparam int CLK_MHZ        = 250;
	localparam int STEP_PULSE_NS  = 1000;
	localparam int STEP_RATE_NS   = 3000000;
	localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int STEP_RATE_CYC  = (STEP_RATE_NS * CLK_MHZ + 999) / 1000;
	localparam int MAX_TRACKS     = 80;
	localparam int SECTOR_WORDS   = 256;
	localparam int PRIO_LIMIT     = 5;

	typedef enum logic [2:0] {
		OP_RESTORE, OP_SEEK, OP_STEP, OP_READ, OP_WRITE, OP_TEST_WR, OP_TEST_RD, OP_NONE
	} fdc_op_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_STEP, ST_VERIFY, ST_SEARCH, ST_XFER, ST_TEST, ST_DONE
	} fdc_st_t;

	// memory bus request carried as one group
	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wpar;
	} fdc_dma_t;

	typedef struct packed {
		fdc_st_t     st;
		fdc_op_t     op;
		logic        ie, fbp, par_err, nxm_err, seek_err;
		logic        lost, rnf, dcrc, hcrc, wp_err, nr_err, prio_err;
		logic [6:0]  tgt_trk, cur_trk;
		logic [4:0]  sector;
		logic [6:0]  steps;
		logic [19:0] tmr;
		logic [1:0]  idx_cnt;
		logic [8:0]  word_cnt;
		logic        data_end;
		logic [15:0] data_reg, buf_word;
		logic        buf_full;
		fdc_dma_t    dma;
		logic        step_out, dir_in;
		logic [3:0]  sync1, sync2;
		logic        idx_prev;
		logic [31:0] prdata;
	} fdc_state_t;
endpackage

// [logic/fdc_ctrl.sv]
// fdc_ctrl: diskette controller with dma, apb registers and status.
// assumes drive status pins are asynchronous; read channel, write channel
// and memory bus are on clk.
`timescale 1ns/1ns
module fdc_ctrl #(
	parameter int STEP_CYC = fdc_pkg::STEP_RATE_CYC
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	output logic                  irq,
	input  wire logic             irq_ack,
	input  wire logic [2:0]       cpu_prio,
	output fdc_pkg::fdc_dma_t     dma,
	input  wire logic             dma_ack,
	input  wire logic             dma_nxm,
	input  wire logic [15:0]      dma_rdata,
	input  wire logic             dma_rpar,
	input  wire logic             drv_trk0,
	input  wire logic             drv_ready,
	input  wire logic             drv_wprot,
	input  wire logic             drv_index,
	output logic                  drv_step,
	output logic                  drv_dir_in,
	input  wire logic             hdr_valid,
	input  wire logic [6:0]       hdr_track,
	input  wire logic [4:0]       hdr_sector,
	input  wire logic             hdr_crc_ok,
	input  wire logic             rd_word_valid,
	input  wire logic [15:0]      rd_word,
	input  wire logic             rd_data_end,
	input  wire logic             rd_crc_ok,
	output logic                  wr_word_valid,
	output logic [15:0]           wr_word,
	input  wire logic             wr_word_take
);
	fdc_pkg::fdc_state_t q, d;
	logic trk0_s, rdy_s, wp_s, idx_rise;
	logic acc, wr_acc, mapped, dma_done, dma_ok, cmd_wr, new_cmd;
	logic [15:0] csr_v, err_v;

	// synchronised drive levels; only sync2 is read by logic
	assign trk0_s   = q.sync2[0];
	assign rdy_s    = q.sync2[1];
	assign wp_s     = q.sync2[2];
	assign idx_rise = q.sync2[3] & ~q.idx_prev;

	// apb decode: zero wait states, unmapped offsets answer with pslverr
	assign acc    = psel & penable;
	assign wr_acc = acc & pwrite;
	always_comb begin
		if (paddr == fdc_pkg::OFS_CSR) begin
			mapped = 1'b1;
		end else if (paddr == fdc_pkg::OFS_CMD) begin
			mapped = 1'b1;
		end else if (paddr == fdc_pkg::OFS_TRACK) begin
			mapped = 1'b1;
		end else if (paddr == fdc_pkg::OFS_ADDR) begin
			mapped = 1'b1;
		end else if (paddr == fdc_pkg::OFS_DATA) begin
			mapped = 1'b1;
		end else if (paddr == fdc_pkg::OFS_ERR) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// status words as software sees them
	always_comb begin
		csr_v = 16'h0000;
		csr_v[fdc_pkg::CSR_PAR]   = q.par_err;
		csr_v[fdc_pkg::CSR_NXM]   = q.nxm_err;
		csr_v[fdc_pkg::CSR_IE]    = q.ie;
		csr_v[fdc_pkg::CSR_FBP]   = q.fbp;
		csr_v[fdc_pkg::CSR_DONE]  = (q.st == fdc_pkg::ST_DONE);
		csr_v[fdc_pkg::CSR_BUSY]  = (q.st != fdc_pkg::ST_IDLE) && (q.st != fdc_pkg::ST_DONE);
		csr_v[fdc_pkg::CSR_SEEK]  = q.seek_err;
		csr_v[fdc_pkg::CSR_TRK0]  = trk0_s;
		csr_v[fdc_pkg::CSR_NRDY]  = ~rdy_s;
		csr_v[fdc_pkg::CSR_WPROT] = wp_s;
		err_v = {9'h000, q.prio_err, q.nr_err, q.wp_err, q.hcrc, q.dcrc, q.rnf, q.lost};
	end

	// a command write is only taken while idle or awaiting acknowledge
	assign cmd_wr  = wr_acc && (paddr == fdc_pkg::OFS_CMD);
	assign new_cmd = cmd_wr && ((q.st == fdc_pkg::ST_IDLE) || (q.st == fdc_pkg::ST_DONE));
	assign dma_done = q.dma.req & (dma_ack | dma_nxm);
	assign dma_ok   = q.dma.req & dma_ack & ~dma_nxm;

	// interrupt only while a finished command waits to be acknowledged
	assign irq = (q.st == fdc_pkg::ST_DONE) && q.ie && (cpu_prio < 3'(fdc_pkg::PRIO_LIMIT));

	// next-state logic for the whole block
	always_comb begin
		d = q;
		d.sync1    = {drv_index, drv_wprot, drv_ready, drv_trk0};
		d.sync2    = q.sync1;
		d.idx_prev = q.sync2[3];
		// read data captured in the setup cycle, held through access
		if (psel && !penable) begin
			if (paddr == fdc_pkg::OFS_CSR) begin
				d.prdata = {16'h0000, csr_v};
			end else if (paddr == fdc_pkg::OFS_TRACK) begin
				d.prdata = {25'h000_0000, q.cur_trk};
			end else if (paddr == fdc_pkg::OFS_ADDR) begin
				d.prdata = {16'h0000, q.dma.addr};
			end else if (paddr == fdc_pkg::OFS_DATA) begin
				d.prdata = {16'h0000, q.data_reg};
			end else if (paddr == fdc_pkg::OFS_ERR) begin
				d.prdata = {16'h0000, err_v};
			end else begin
				d.prdata = 32'h0000_0000;
			end
		end
		// software writes; address and data only loadable when idle
		if (wr_acc && paddr == fdc_pkg::OFS_CSR) begin
			d.ie  = pwdata[fdc_pkg::CSR_IE];
			d.fbp = pwdata[fdc_pkg::CSR_FBP];
		end
		if (wr_acc && paddr == fdc_pkg::OFS_ADDR && q.st == fdc_pkg::ST_IDLE) begin
			d.dma.addr = pwdata[15:0];
		end
		if (wr_acc && paddr == fdc_pkg::OFS_DATA && q.st == fdc_pkg::ST_IDLE) begin
			d.data_reg = pwdata[15:0];
		end
		// acknowledge at priority five or above is a misuse
		if (irq_ack && q.st == fdc_pkg::ST_DONE) begin
			d.st = fdc_pkg::ST_IDLE;
			if (cpu_prio >= 3'(fdc_pkg::PRIO_LIMIT)) begin
				d.prio_err = 1'b1;
			end
		end
		// new command: clear flags first so later sets win
		if (new_cmd) begin
			{d.par_err, d.nxm_err, d.seek_err} = 3'b000;
			{d.lost, d.rnf, d.dcrc, d.hcrc, d.wp_err, d.nr_err, d.prio_err} = 7'h00;
			d.op       = fdc_pkg::fdc_op_t'(pwdata[fdc_pkg::CMD_OP_LO +: 3]);
			d.tgt_trk  = pwdata[fdc_pkg::CMD_TRK_LO +: 7];
			d.sector   = pwdata[fdc_pkg::CMD_SEC_LO +: 5];
			d.steps    = 7'h00;
			d.tmr      = 20'h0_0000;
			d.idx_cnt  = 2'b00;
			d.word_cnt = 9'h000;
			d.data_end = 1'b0;
			d.buf_full = 1'b0;
			d.dir_in   = 1'b0;
			case (fdc_pkg::fdc_op_t'(pwdata[fdc_pkg::CMD_OP_LO +: 3]))
				fdc_pkg::OP_TEST_WR, fdc_pkg::OP_TEST_RD: begin
					d.st = fdc_pkg::ST_TEST;
				end
				fdc_pkg::OP_NONE: begin
					d.st = fdc_pkg::ST_DONE;
				end
				default: begin
					d.st = fdc_pkg::ST_STEP;
				end
			endcase
			// drive checks refuse the command outright
			if (pwdata[fdc_pkg::CMD_OP_LO +: 3] <= 3'(fdc_pkg::OP_WRITE) && !rdy_s) begin
				d.nr_err = 1'b1;
				d.st     = fdc_pkg::ST_DONE;
			end else if (fdc_pkg::fdc_op_t'(pwdata[fdc_pkg::CMD_OP_LO +: 3]) == fdc_pkg::OP_WRITE
				&& wp_s) begin
				d.wp_err = 1'b1;
				d.st     = fdc_pkg::ST_DONE;
			end
		end
		// dma completion: nxm excludes parity, counter steps only on success
		if (dma_done) begin
			d.dma.req = 1'b0;
			if (dma_nxm) begin
				d.nxm_err = 1'b1;
			end else begin
				d.dma.addr = q.dma.addr + 16'h0001;
				if (!q.dma.we && (dma_rpar != ^dma_rdata)) begin
					d.par_err = 1'b1;
				end
			end
		end
		if (idx_rise && !new_cmd) begin
			d.idx_cnt = q.idx_cnt + 2'b01;
		end
		// command sequencing
		case (q.st)
			fdc_pkg::ST_STEP: begin
				// reads and writes work on the current track, no motion
				if (q.op == fdc_pkg::OP_READ || q.op == fdc_pkg::OP_WRITE) begin
					d.st      = fdc_pkg::ST_SEARCH;
					d.idx_cnt = 2'b00;
				end else if (q.tmr != 20'h0_0000) begin
					d.tmr = q.tmr - 20'h0_0001;
					if (q.tmr == 20'(STEP_CYC - fdc_pkg::STEP_PULSE_CYC)) begin
						d.step_out = 1'b0;
						d.cur_trk  = q.dir_in ? q.cur_trk + 7'h01 : q.cur_trk - 7'h01;
					end
				end else if ((q.op == fdc_pkg::OP_RESTORE && trk0_s)
					|| (q.op == fdc_pkg::OP_SEEK && q.cur_trk == q.tgt_trk)
					|| (q.op == fdc_pkg::OP_STEP && q.steps != 7'h00)) begin
					if (q.op == fdc_pkg::OP_RESTORE) begin
						d.cur_trk = fdc_pkg::RST_TRK;
					end
					d.st      = fdc_pkg::ST_VERIFY;
					d.idx_cnt = 2'b00;
				end else if (q.steps == 7'(fdc_pkg::MAX_TRACKS)) begin
					d.seek_err = 1'b1;
					d.st       = fdc_pkg::ST_DONE;
				end else begin
					d.dir_in   = (q.op == fdc_pkg::OP_STEP)
						|| (q.op == fdc_pkg::OP_SEEK && q.tgt_trk > q.cur_trk);
					d.step_out = 1'b1;
					d.tmr      = 20'(STEP_CYC);
					d.steps    = q.steps + 7'h01;
				end
			end
			fdc_pkg::ST_VERIFY: begin
				// position verify on the first header read
				if (hdr_valid) begin
					d.st = fdc_pkg::ST_DONE;
					if (!hdr_crc_ok) begin
						d.hcrc = 1'b1;
					end else if (hdr_track != q.cur_trk) begin
						d.seek_err = 1'b1;
					end
				end else if (q.idx_cnt == 2'b10) begin
					d.seek_err = 1'b1;
					d.st       = fdc_pkg::ST_DONE;
				end
			end
			fdc_pkg::ST_SEARCH: begin
				if (hdr_valid && !hdr_crc_ok) begin
					d.hcrc = 1'b1;
					d.st   = fdc_pkg::ST_DONE;
				end else if (hdr_valid && hdr_track == q.cur_trk && hdr_sector == q.sector) begin
					d.st = fdc_pkg::ST_XFER;
				end else if (q.idx_cnt == 2'b10) begin
					d.rnf = 1'b1;
					d.st  = fdc_pkg::ST_DONE;
				end
			end
			fdc_pkg::ST_XFER: begin
				if (q.op == fdc_pkg::OP_READ) begin
					// single holding word: a second word before dma drains is lost
					if (dma_ok) begin
						d.buf_full = 1'b0;
						d.word_cnt = q.word_cnt + 9'h001;
					end
					if (rd_word_valid) begin
						if (q.buf_full && !dma_ok) begin
							d.lost = 1'b1;
						end else begin
							d.buf_word = rd_word;
							d.buf_full = 1'b1;
						end
					end
					if (q.buf_full && !q.dma.req) begin
						d.dma.req   = 1'b1;
						d.dma.we    = 1'b1;
						d.dma.wdata = q.buf_word;
						d.dma.wpar  = ^q.buf_word ^ q.fbp;
					end
					if (rd_data_end) begin
						d.data_end = 1'b1;
						if (!rd_crc_ok) begin
							d.dcrc = 1'b1;
						end
					end
					if (q.data_end && !q.buf_full && !q.dma.req) begin
						d.st = fdc_pkg::ST_DONE;
					end
				end else begin
					// write: prefetch one word ahead of the drive
					if (dma_ok) begin
						d.buf_word = dma_rdata;
						d.buf_full = 1'b1;
					end
					if (wr_word_take) begin
						if (!q.buf_full) begin
							d.lost = 1'b1;
						end else begin
							d.buf_full = 1'b0;
						end
						d.word_cnt = q.word_cnt + 9'h001;
					end
					if (!q.buf_full && !q.dma.req && q.word_cnt < 9'(fdc_pkg::SECTOR_WORDS)
						&& !wr_word_take) begin
						d.dma.req = 1'b1;
						d.dma.we  = 1'b0;
					end
					if (q.word_cnt == 9'(fdc_pkg::SECTOR_WORDS) && !q.dma.req) begin
						d.st = fdc_pkg::ST_DONE;
					end
				end
				// a memory fault ends the transfer
				if (dma_done && dma_nxm) begin
					d.st = fdc_pkg::ST_DONE;
				end
			end
			fdc_pkg::ST_TEST: begin
				// one word between data register and memory, drive untouched
				if (!q.dma.req && q.word_cnt == 9'h000) begin
					d.dma.req   = 1'b1;
					d.dma.we    = (q.op == fdc_pkg::OP_TEST_WR);
					d.dma.wdata = q.data_reg;
					d.dma.wpar  = ^q.data_reg ^ q.fbp;
					d.word_cnt  = 9'h001;
				end else if (dma_done) begin
					if (dma_ok && !q.dma.we) begin
						d.data_reg = dma_rdata;
					end
					d.st = fdc_pkg::ST_DONE;
				end
			end
			default: begin
			end
		endcase
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q          <= '0;
			q.st       <= fdc_pkg::ST_IDLE;
			q.op       <= fdc_pkg::OP_NONE;
			q.dma.addr <= fdc_pkg::RST_ADDR;
			q.cur_trk  <= fdc_pkg::RST_TRK;
		end else if (ce) begin
			q <= d;
		end
	end

	assign prdata        = q.prdata;
	assign dma           = q.dma;
	assign drv_step      = q.step_out;
	assign drv_dir_in    = q.dir_in;
	assign wr_word_valid = q.buf_full && q.st == fdc_pkg::ST_XFER && q.op == fdc_pkg::OP_WRITE;
	assign wr_word       = q.buf_word;

	// checks
	sequence s_nxm_end;
		q.dma.req && dma_nxm && ce;
	endsequence
	sequence s_ok_end;
		q.dma.req && dma_ack && !dma_nxm && ce;
	endsequence
	chk_irq_enable_gate: assert property (@(posedge clk) disable iff (!nrst)
		!q.ie |-> !irq) else $error("interrupt raised with enable clear");
	chk_irq_cmd_only: assert property (@(posedge clk) disable iff (!nrst)
		irq |-> q.st == fdc_pkg::ST_DONE) else $error("interrupt without command");
	chk_irq_prio: assert property (@(posedge clk) disable iff (!nrst)
		irq |-> cpu_prio < 3'(fdc_pkg::PRIO_LIMIT)) else $error("interrupt at high priority");
	chk_done_irq: assert property (@(posedge clk) disable iff (!nrst)
		(ce && q.st != fdc_pkg::ST_DONE && d.st == fdc_pkg::ST_DONE && q.ie && cpu_prio == 3'd0)
		|=> irq || !ce || $past(irq_ack)) else $error("finished command did not interrupt");
	chk_nxm_no_par: assert property (@(posedge clk) disable iff (!nrst)
		s_nxm_end |=> q.nxm_err && ($past(q.par_err) == q.par_err)) else $error("nxm with parity");
	chk_addr_step: assert property (@(posedge clk) disable iff (!nrst)
		s_ok_end |=> q.dma.addr == $past(q.dma.addr) + 16'h0001) else $error("address not advanced");
	chk_par_flag: assert property (@(posedge clk) disable iff (!nrst)
		(s_ok_end and !q.dma.we && dma_rpar != ^dma_rdata) |=> q.par_err) else $error("parity missed");
	chk_force_par: assert property (@(posedge clk) disable iff (!nrst)
		q.dma.req && q.dma.we |-> q.dma.wpar == (^q.dma.wdata ^ q.fbp)) else $error("bad write parity");
	chk_cmd_clears: assert property (@(posedge clk) disable iff (!nrst)
		(new_cmd && ce && !dma_done) |=> !q.par_err && !q.lost && !q.rnf) else $error("flags not cleared");
	chk_wprot_refuse: assert property (@(posedge clk) disable iff (!nrst)
		(new_cmd && ce && wp_s && rdy_s && pwdata[2:0] == 3'(fdc_pkg::OP_WRITE))
		|=> q.wp_err && q.st == fdc_pkg::ST_DONE) else $error("protected write not refused");
endmodule // fdc_ctrl

// [testbench/fdc_drv_model.sv]
// fdc_drv_model: behavioural diskette drive plus memory bus slave.
// assumes fdc_pkg compiled first; knob inputs come from the bench.
`timescale 1ns/1ns
module fdc_drv_model #(
	parameter int          IDX_CYC  = 1000,
	parameter logic [15:0] NXM_BASE = 16'h8000
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire fdc_pkg::fdc_dma_t dma,
	output logic                   dma_ack,
	output logic                   dma_nxm,
	output logic [15:0]            dma_rdata,
	output logic                   dma_rpar,
	input  wire logic              drv_step,
	input  wire logic              drv_dir_in,
	output logic                   drv_trk0,
	output logic                   drv_ready,
	output logic                   drv_wprot,
	output logic                   drv_index,
	output logic                   hdr_valid,
	output logic [6:0]             hdr_track,
	output logic [4:0]             hdr_sector,
	output logic                   hdr_crc_ok,
	input  wire logic              wr_word_valid,
	output logic                   wr_word_take,
	input  wire logic              slow,
	input  wire logic              ofs,
	input  wire logic              hdr_bad,
	input  wire logic              no_media,
	input  wire logic              wprot_in,
	input  wire logic              take_fast,
	input  wire logic [15:0]       bad_par_addr,
	output logic [15:0]            last_waddr,
	output logic [15:0]            last_wdata,
	output logic                   last_wpar
);
	logic [3:0]  wait_cnt;
	logic        answered;
	logic [6:0]  pos;
	logic        step_d;
	logic [11:0] tick;
	logic [15:0] word;

	// door open or write tab shown as plain levels
	assign drv_ready = !no_media;
	assign drv_wprot = wprot_in;
	assign drv_trk0  = (pos == 7'h00);
	assign word      = dma.addr ^ 16'h5a5a;

	// memory answers once per request; idle data toggles so stale values never match
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{dma_ack, dma_nxm, dma_rpar, answered, step_d, drv_index, hdr_valid} <= '0;
			{hdr_crc_ok, wr_word_take, last_wpar, last_waddr, last_wdata} <= '0;
			{dma_rdata, wait_cnt, tick, hdr_track, hdr_sector} <= '0;
			pos        <= 7'h03;
		end else begin
			dma_ack   <= 1'b0;
			dma_nxm   <= 1'b0;
			dma_rdata <= ~dma_rdata;
			dma_rpar  <= ~dma_rpar;
			if (!dma.req)
				answered <= 1'b0;
			if (dma.req && !answered) begin
				if (wait_cnt >= (slow ? 4'h6 : 4'h1)) begin
					answered <= 1'b1;
					wait_cnt <= 4'h0;
					if (dma.addr >= NXM_BASE)
						dma_nxm <= 1'b1;
					else if (dma.we) begin
						dma_ack    <= 1'b1;
						last_waddr <= dma.addr;
						last_wdata <= dma.wdata;
						last_wpar  <= dma.wpar;
					end else begin
						dma_ack   <= 1'b1;
						dma_rdata <= word;
						dma_rpar  <= (^word) ^ (dma.addr == bad_par_addr);
					end
				end else
					wait_cnt <= wait_cnt + 4'h1;
			end
			// head moves on each step pulse, never past track zero
			step_d <= drv_step;
			if (drv_step && !step_d)
				pos <= drv_dir_in ? pos + 7'h01 : (pos == 7'h00 ? pos : pos - 7'h01);
			tick       <= (tick == 12'(IDX_CYC - 1)) ? 12'h000 : tick + 12'h001;
			drv_index  <= (tick < 12'h004);
			hdr_valid  <= (tick[6:0] == 7'h32) && !drv_step;
			hdr_track  <= (tick[6:0] == 7'h32) ? pos + 7'(ofs) : ~hdr_track;
			hdr_sector <= 5'h01;
			hdr_crc_ok <= !hdr_bad;
			// fast mode takes every cycle so the buffer runs dry
			wr_word_take <= take_fast || (wr_word_valid && !wr_word_take);
		end
	end
endmodule // fdc_drv_model

// [testbench/tb.sv]
// tb: self-checking bench for the diskette dma controller over apb.
// assumes fdc_pkg, fdc_ctrl and fdc_drv_model are compiled before it.
`timescale 1ns/1ns
module tb;
	logic              clk, nrst, psel, penable, pwrite, pready, pslverr, irq, irq_ack;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata;
	logic [2:0]        cpu_prio;
	fdc_pkg::fdc_dma_t dma;
	logic              dma_ack, dma_nxm, dma_rpar, trk0, rdy, wp, idx, step, dir_in;
	logic [15:0]       dma_rdata, wr_word, last_waddr, last_wdata, bad_par_addr;
	logic              hdr_valid, hdr_crc_ok, wr_valid, wr_take, last_wpar;
	logic [6:0]        hdr_track;
	logic [4:0]        hdr_sector;
	logic              slow, ofs, hdr_bad, no_media, wprot_in, take_fast, data_bad;
	int                n_fail, checks;

	// short step interval keeps seeks within a few thousand cycles
	fdc_ctrl #(.STEP_CYC(600)) fdc_ctrl_i (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .irq_ack(irq_ack), .cpu_prio(cpu_prio),
		.dma(dma), .dma_ack(dma_ack), .dma_nxm(dma_nxm), .dma_rdata(dma_rdata),
		.dma_rpar(dma_rpar), .drv_trk0(trk0), .drv_ready(rdy), .drv_wprot(wp),
		.drv_index(idx), .drv_step(step), .drv_dir_in(dir_in), .hdr_valid(hdr_valid),
		.hdr_track(hdr_track), .hdr_sector(hdr_sector), .hdr_crc_ok(hdr_crc_ok),
		.rd_word_valid(1'b0), .rd_word(16'h0000), .rd_data_end(hdr_valid), .rd_crc_ok(~data_bad),
		.wr_word_valid(wr_valid), .wr_word(wr_word), .wr_word_take(wr_take));

	fdc_drv_model fdc_drv_model_i (.clk(clk), .nrst(nrst), .dma(dma), .dma_ack(dma_ack),
		.dma_nxm(dma_nxm), .dma_rdata(dma_rdata), .dma_rpar(dma_rpar), .drv_step(step),
		.drv_dir_in(dir_in), .drv_trk0(trk0), .drv_ready(rdy), .drv_wprot(wp),
		.drv_index(idx), .hdr_valid(hdr_valid), .hdr_track(hdr_track),
		.hdr_sector(hdr_sector), .hdr_crc_ok(hdr_crc_ok), .wr_word_valid(wr_valid),
		.wr_word_take(wr_take), .slow(slow), .ofs(ofs), .hdr_bad(hdr_bad),
		.no_media(no_media), .wprot_in(wprot_in), .take_fast(take_fast),
		.bad_par_addr(bad_par_addr), .last_waddr(last_waddr), .last_wdata(last_wdata),
		.last_wpar(last_wpar));

	// 250 MHz core clock
	initial clk = 1'b0;
	always #2 clk = ~clk;

	task automatic end_sim();
		$display("checks %0d, n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		for (n = 0; n < 50 && pready !== 1'b1; n++)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 50)
			chk(32'h0000_0000, 32'h0000_0001);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r & m, x);
	endtask

	function automatic logic [31:0] mk_cmd(input logic [2:0] op, input logic [6:0] t,
			input logic [4:0] s);
		return {17'h0_0000, s, t, op};
	endfunction

	// issue a command after drive levels settle, then poll done
	task automatic run(input logic [31:0] c);
		logic [31:0] r;
		logic        e;
		int          i;
		repeat (4) @(posedge clk);
		wr(fdc_pkg::OFS_CMD, c);
		r = 32'h0000_0000;
		for (i = 0; i < 10000 && r[fdc_pkg::CSR_DONE] !== 1'b1; i++)
			apb(1'b0, fdc_pkg::OFS_CSR, 32'h0000_0000, r, e);
		chk(32'(r[fdc_pkg::CSR_DONE]), 32'h0000_0001);
	endtask

	task automatic ack();
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// watchdog well beyond the expected run of about 13k cycles
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		end_sim();
	end

	initial begin
		logic [31:0] r;
		logic        e;
		{psel, penable, pwrite, irq_ack, slow, ofs, hdr_bad, no_media, wprot_in, data_bad} = '0;
		take_fast    = 1'b0;
		paddr        = 8'h00;
		pwdata       = 32'h0000_0000;
		cpu_prio     = 3'h0;
		bad_par_addr = 16'hffff;
		nrst         = 1'b0;
		n_fail       = 0;
		checks       = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		// reset values, control bits, unmapped offset
		expect_reg(fdc_pkg::OFS_CSR, 32'hffff_ffff, 32'h0000_0000);
		expect_reg(fdc_pkg::OFS_TRACK, 32'h0000_007f, 32'h0000_0000);
		expect_reg(fdc_pkg::OFS_ADDR, 32'h0000_ffff, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0000_0000, r, e);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		wr(fdc_pkg::OFS_CSR, 32'hffff_ffff);
		expect_reg(fdc_pkg::OFS_CSR, 32'h0000_2800, 32'h0000_2800);
		wr(fdc_pkg::OFS_CSR, 32'h0000_0000);
		// test write with interrupts off
		wr(fdc_pkg::OFS_ADDR, 32'h0000_0040);
		wr(fdc_pkg::OFS_DATA, 32'h0000_1234);
		run(mk_cmd(3'h5, 7'h00, 5'h00));
		chk(32'(irq), 32'h0000_0000);
		chk(32'(last_waddr), 32'h0000_0040);
		chk(32'(last_wdata), 32'h0000_1234);
		chk(32'(last_wpar), 32'(^16'h1234));
		expect_reg(fdc_pkg::OFS_ADDR, 32'h0000_ffff, 32'h0000_0041);
		ack();
		// forced bad parity, slow memory, interrupt on
		wr(fdc_pkg::OFS_CSR, 32'h0000_2800);
		slow <= 1'b1;
		wr(fdc_pkg::OFS_DATA, 32'h0000_00ff);
		run(mk_cmd(3'h5, 7'h00, 5'h00));
		chk(32'(irq), 32'h0000_0001);
		chk(32'(last_wpar), 32'(1'b1 ^ (^16'h00ff)));
		expect_reg(fdc_pkg::OFS_ADDR, 32'h0000_ffff, 32'h0000_0042);
		ack();
		chk(32'(irq), 32'h0000_0000);
		slow <= 1'b0;
		// test read of a bad-parity word, then priority masking
		bad_par_addr <= 16'h0042;
		wr(fdc_pkg::OFS_CSR, 32'h0000_2000);
		run(mk_cmd(3'h6, 7'h00, 5'h00));
		expect_reg(fdc_pkg::OFS_CSR, 32'h0000_c000, 32'h0000_8000);
		expect_reg(fdc_pkg::OFS_DATA, 32'h0000_ffff, 32'h0000_5a18);
		cpu_prio <= 3'h5;
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0000_0000);
		ack();
		expect_reg(fdc_pkg::OFS_ERR, 32'h0000_0040, 32'h0000_0040);
		cpu_prio <= 3'h0;
		ack();
		// access to absent memory
		wr(fdc_pkg::OFS_ADDR, 32'h0000_f000);
		run(mk_cmd(3'h6, 7'h00, 5'h00));
		expect_reg(fdc_pkg::OFS_CSR, 32'h0000_c000, 32'h0000_4000);
		expect_reg(fdc_pkg::OFS_ERR, 32'h0000_0040, 32'h0000_0000);
		expect_reg(fdc_pkg::OFS_ADDR, 32'h0000_ffff, 32'h0000_f000);
		ack();
		// restore, seek, step
		run(mk_cmd(3'h0, 7'h00, 5'h00));
		expect_reg(fdc_pkg::OFS_CSR, 32'h0000_4014, 32'h0000_0004);
		expect_reg(fdc_pkg::OFS_TRACK, 32'h0000_007f, 32'h0000_0000);
		ack();
		run(mk_cmd(3'h1, 7'h05, 5'h00));
		expect_reg(fdc_pkg::OFS_CSR, 32'h0000_0014, 32'h0000_0000);
		expect_reg(fdc_pkg::OFS_TRACK, 32'h0000_007f, 32'h0000_0005);
		ack();
		run(mk_cmd(3'h2, 7'h00, 5'h00));
		expect_reg(fdc_pkg::OFS_TRACK, 32'h0000_007f, 32'h0000_0006);
		ack();
		// headers one track off make the seek fail
		ofs <= 1'b1;
		run(mk_cmd(3'h1, 7'h02, 5'h00));
		expect_reg(fdc_pkg::OFS_CSR, 32'h0000_0010, 32'h0000_0010);
		ack();
		ofs <= 1'b0;
		run(mk_cmd(3'h0, 7'h00, 5'h00));
		ack();
		// missing sector, bad header, bad data crc, starved write
		run(mk_cmd(3'h3, 7'h00, 5'h09));
		expect_reg(fdc_pkg::OFS_ERR, 32'h0000_007f, 32'h0000_0002);
		ack();
		hdr_bad <= 1'b1;
		run(mk_cmd(3'h3, 7'h00, 5'h01));
		expect_reg(fdc_pkg::OFS_ERR, 32'h0000_0008, 32'h0000_0008);
		ack();
		hdr_bad   <= 1'b0;
		data_bad  <= 1'b1;
		run(mk_cmd(3'h3, 7'h00, 5'h01));
		expect_reg(fdc_pkg::OFS_ERR, 32'h0000_000f, 32'h0000_0004);
		ack();
		data_bad  <= 1'b0;
		take_fast <= 1'b1;
		run(mk_cmd(3'h4, 7'h00, 5'h01));
		expect_reg(fdc_pkg::OFS_ERR, 32'h0000_0001, 32'h0000_0001);
		ack();
		take_fast <= 1'b0;
		// protected medium, then empty drive
		wprot_in <= 1'b1;
		run(mk_cmd(3'h4, 7'h00, 5'h01));
		expect_reg(fdc_pkg::OFS_ERR, 32'h0000_0010, 32'h0000_0010);
		expect_reg(fdc_pkg::OFS_CSR, 32'h0000_0001, 32'h0000_0001);
		ack();
		wprot_in <= 1'b0;
		no_media <= 1'b1;
		run(mk_cmd(3'h3, 7'h00, 5'h01));
		expect_reg(fdc_pkg::OFS_ERR, 32'h0000_0020, 32'h0000_0020);
		expect_reg(fdc_pkg::OFS_CSR, 32'h0000_0002, 32'h0000_0002);
		ack();
		end_sim();
	end
endmodule // tb
